// [hw/emb_port.sv]
// external memory bus port with request fifo, strobe sequencer and pin drivers
`timescale 1ns/10ps

// ---------------------------------------------------------------
// request fifo
// ---------------------------------------------------------------
module emb_fifo #(
  parameter int unsigned WIDTH = 35,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [PW:0]      count_ff;
  logic [PW:0]      nxt_count;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign nxt_count = count_ff + (PW+1)'(push) - (PW+1)'(pop);
  assign out_valid = (count_ff != '0);
  assign out_data  = mem[rd_ptr_ff];

  // storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
      in_ready  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= nxt_count;
      // not-full flag kept in a flop so the ready pin has no logic behind it
      in_ready <= (nxt_count != (PW+1)'(DEPTH));
    end
  end
endmodule : emb_fifo

// Function
// - drive 16-bit address bus, bit 0 lsb, shared by data, program, I/O
// - address floats when emulation float low, holds last value in power-down
// - 16-bit bidirectional data bus carries data both ways
// - data bus driven only for write data, else floated
// - space selects stay high, only the accessed space's select goes low
// - space selects float in reset, power-down and emulation float
// - ready low sampled: wait one cycle, then sample ready again
// - direction high for read, low only in writes, floats when idle off
// - strobe low only during an external bus cycle, floats when off
// - write data driven from address setup, one cycle before write-enable falls, captured at its rise
// - write-enable pulses low on every write, floats in reset and emulation float
// - second direction output is always the inverse of direction
// - global request low during global data space accesses, floats when off
module emb_port
  import emb_pkg::*;
#(
  parameter int unsigned AW    = EMB_AW,
  parameter int unsigned DW    = EMB_DW,
  parameter int unsigned DEPTH = EMB_FIFO_DEPTH
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          req_valid,
  output logic               req_ready,
  input  wire logic          req_write,
  input  wire logic [1:0]    req_space,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_wdata,
  output logic               rd_valid,
  output logic      [DW-1:0] rd_data,
  input  wire logic          power_down,
  input  wire logic          emulation_float_n,
  input  wire logic          ready,
  output logic      [AW-1:0] ext_address_bus,
  output logic               ext_address_bus_oe_n,
  input  wire logic [DW-1:0] ext_data_bus_in,
  output logic      [DW-1:0] ext_data_bus,
  output logic               ext_data_bus_oe_n,
  output logic               data_space_select_n,
  output logic               program_space_select_n,
  output logic               io_space_select_n,
  output logic               global_space_request_n,
  output logic               external_cycle_strobe_n,
  output logic               read_write_dir,
  output logic               write_read_dir_n,
  output logic               write_enable_n,
  output logic               ctrl_oe_n,
  output logic               write_enable_oe_n
);
  localparam int unsigned FW = 1 + 2 + AW + DW;

  // ---------------------------------------------------------------
  // request buffering
  // ---------------------------------------------------------------
  logic          f_valid;
  logic          f_ready;
  logic [FW-1:0] f_data;
  logic          f_write;
  logic [1:0]    f_space;
  logic [AW-1:0] f_addr;
  logic [DW-1:0] f_wdata;

  emb_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   ({req_write, req_space, req_addr, req_wdata}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );
  assign {f_write, f_space, f_addr, f_wdata} = f_data;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  emb_state_t    state_ff;
  emb_state_t    nxt_state;
  logic          cur_write_ff;
  logic [1:0]    cur_space_ff;
  logic [DW-1:0] cur_wdata_ff;
  logic          off;

  assign off     = power_down || !emulation_float_n;
  assign f_ready = (state_ff == EMB_IDLE) && !power_down;

  // request shown on the pins: the one being popped, else the one in flight,
  // so the address phase never carries the previous access's space or data
  logic          pop_req;
  logic          nxt_write;
  logic [1:0]    nxt_space;
  logic [DW-1:0] nxt_wdata;
  assign pop_req   = f_valid && f_ready;
  assign nxt_write = pop_req ? f_write : cur_write_ff;
  assign nxt_space = pop_req ? f_space : cur_space_ff;
  assign nxt_wdata = pop_req ? f_wdata : cur_wdata_ff;

  // next state: idle, address setup, strobe low with waits, recovery
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      EMB_IDLE:  if (f_valid && !power_down) nxt_state = EMB_ADDR;
      EMB_ADDR:  nxt_state = EMB_EXTERNAL_CYCLE_STROBE_N;
      EMB_EXTERNAL_CYCLE_STROBE_N:  if (ready) nxt_state = EMB_RECOV;
      EMB_RECOV: nxt_state = EMB_IDLE;
      default:   nxt_state = EMB_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= EMB_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // latched request, stable for the whole cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_write_ff    <= 1'b0;
      cur_space_ff    <= EMB_SP_DATA;
      cur_wdata_ff    <= '0;
      ext_address_bus <= '0;
    end else if (f_valid && f_ready) begin
      cur_write_ff    <= f_write;
      cur_space_ff    <= f_space;
      cur_wdata_ff    <= f_wdata;
      ext_address_bus <= f_addr;
    end
  end

  // ---------------------------------------------------------------
  // pin values
  // ---------------------------------------------------------------
  logic act;
  assign act = (nxt_state == EMB_ADDR) || (nxt_state == EMB_EXTERNAL_CYCLE_STROBE_N);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_space_select_n     <= 1'b1;
      program_space_select_n  <= 1'b1;
      io_space_select_n       <= 1'b1;
      global_space_request_n  <= 1'b1;
      external_cycle_strobe_n <= 1'b1;
      read_write_dir          <= 1'b1;
      write_read_dir_n        <= 1'b0;
      write_enable_n          <= 1'b1;
      ext_data_bus            <= '0;
    end else begin
      // select follows space; global also drives data select
      data_space_select_n    <= !(act && (cur_sp(EMB_SP_DATA) || cur_sp(EMB_SP_GLOBAL)));
      program_space_select_n <= !(act && cur_sp(EMB_SP_PROG));
      io_space_select_n      <= !(act && cur_sp(EMB_SP_IO));
      global_space_request_n <= !(act && cur_sp(EMB_SP_GLOBAL));
      external_cycle_strobe_n <= !(nxt_state == EMB_EXTERNAL_CYCLE_STROBE_N);
      read_write_dir          <= !(act && nxt_write);
      write_read_dir_n        <= act && nxt_write;
      write_enable_n          <= !((nxt_state == EMB_EXTERNAL_CYCLE_STROBE_N) && nxt_write);
      ext_data_bus            <= nxt_wdata;
    end
  end

  function automatic logic cur_sp(input logic [1:0] sp);
    cur_sp = (nxt_space == sp) && (nxt_state != EMB_IDLE);
  endfunction : cur_sp

  // ---------------------------------------------------------------
  // enables: low while driving
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ext_address_bus_oe_n <= 1'b1;
      ext_data_bus_oe_n    <= 1'b1;
      ctrl_oe_n            <= 1'b1;
      write_enable_oe_n    <= 1'b1;
    end else begin
      ext_address_bus_oe_n <= !emulation_float_n;
      ext_data_bus_oe_n    <= off || !(act && nxt_write);
      ctrl_oe_n            <= off;
      write_enable_oe_n    <= !emulation_float_n;
    end
  end

  // ---------------------------------------------------------------
  // read return
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= (state_ff == EMB_EXTERNAL_CYCLE_STROBE_N) && ready && !cur_write_ff;
      if ((state_ff == EMB_EXTERNAL_CYCLE_STROBE_N) && ready && !cur_write_ff) begin
        rd_data <= ext_data_bus_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_wait_low;
    !ready && (state_ff == EMB_EXTERNAL_CYCLE_STROBE_N);
  endsequence

  a_wait_holds: assert property (@(posedge ref_clk) disable iff (rst)
    s_wait_low |=> (state_ff == EMB_EXTERNAL_CYCLE_STROBE_N)) else $error("ready low did not wait");
  a_strobe_stable: assert property (@(posedge ref_clk) disable iff (rst)
    (!external_cycle_strobe_n && $past(!external_cycle_strobe_n))
    |-> $stable(ext_address_bus) && $stable(read_write_dir)) else $error("bus moved");
  a_dir_inverse: assert property (@(posedge ref_clk) disable iff (rst)
    write_read_dir_n == !read_write_dir) else $error("dir not inverse");
  a_one_select: assert property (@(posedge ref_clk) disable iff (rst)
    $onehot0({!program_space_select_n, !io_space_select_n, !data_space_select_n}))
    else $error("two selects low");
  a_we_write: assert property (@(posedge ref_clk) disable iff (rst)
    !write_enable_n |-> !read_write_dir && !external_cycle_strobe_n)
    else $error("we outside write");
  a_data_drive: assert property (@(posedge ref_clk) disable iff (rst)
    !ext_data_bus_oe_n |-> !read_write_dir) else $error("data driven on read");
  a_float_off: assert property (@(posedge ref_clk) disable iff (rst)
    !emulation_float_n |=> ctrl_oe_n && ext_address_bus_oe_n && write_enable_oe_n)
    else $error("not floated");
  a_strobe_recov: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(external_cycle_strobe_n) |-> ##1 external_cycle_strobe_n)
    else $error("no recovery");
  a_global_req: assert property (@(posedge ref_clk) disable iff (rst)
    !global_space_request_n |-> !data_space_select_n) else $error("global no ds");
  a_select_in_cycle: assert property (@(posedge ref_clk) disable iff (rst)
    !external_cycle_strobe_n
    |-> !(data_space_select_n && program_space_select_n && io_space_select_n))
    else $error("strobe without select");
  a_data_pd_float: assert property (@(posedge ref_clk) disable iff (rst)
    power_down |=> ext_data_bus_oe_n) else $error("data driven in power-down");
  a_dir_idle_read: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == EMB_IDLE) |-> read_write_dir) else $error("dir low while idle");
endmodule : emb_port

// [pkg/emb_pkg.sv]
// package for the external memory bus port: states, widths and timing counts
package emb_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned EMB_AW          = 16;
  localparam int unsigned EMB_DW          = 16;
  localparam int unsigned EMB_FIFO_DEPTH  = 32;

  // ---------------------------------------------------------------
  // space codes carried with each request
  // ---------------------------------------------------------------
  localparam logic [1:0] EMB_SP_DATA   = 2'h0;
  localparam logic [1:0] EMB_SP_PROG   = 2'h1;
  localparam logic [1:0] EMB_SP_IO     = 2'h2;
  localparam logic [1:0] EMB_SP_GLOBAL = 2'h3;

  // ---------------------------------------------------------------
  // timing: one bus cycle equals one clock at 20 MHz
  // ---------------------------------------------------------------
  localparam int unsigned EMB_CLK_NS   = 50;
  localparam int unsigned EMB_WAIT_NS  = 50;
  localparam int unsigned EMB_WAIT_CYC = (EMB_WAIT_NS + EMB_CLK_NS - 1) / EMB_CLK_NS;

  // ---------------------------------------------------------------
  // bus sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EMB_IDLE  = 2'b00,
    EMB_ADDR  = 2'b01,
    EMB_EXTERNAL_CYCLE_STROBE_N  = 2'b10,
    EMB_RECOV = 2'b11
  } emb_state_t;

endpackage : emb_pkg

// [sim/emb_mem_model.sv]
// behavioural external memory that answers the bus port, with a settable ready stall
`timescale 1ns/10ps
module emb_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        strobe_n,
  input  wire logic        rw,
  input  wire logic        we_n,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] dbus,
  input  wire logic [3:0]  slow,
  output logic             ready,
  output logic      [15:0] rdata
);
  logic [15:0] mem [256];
  logic [3:0]  cnt_ff = 4'h0;
  logic [15:0] junk_ff = 16'hA5C3;
  logic [15:0] wr_hold;
  // count strobe-low cycles; released bus shows a changing pattern
  always @(posedge ref_clk) begin
    cnt_ff  <= strobe_n ? 4'h0 : cnt_ff + 4'h1;
    junk_ff <= junk_ff + 16'h3C5B;
  end
  // ready only after the stall count has run out
  assign ready = (cnt_ff >= slow);
  // read data only while strobed in read direction
  assign rdata = (!strobe_n && rw) ? mem[addr[7:0]] : junk_ff;
  // data sampled mid-cycle while write enable is low, since the bus is released
  // in the same step as the enable rises; stored on the rising edge
  always @(negedge ref_clk) begin
    if (!we_n) wr_hold <= dbus;
  end
  always @(posedge we_n) mem[addr[7:0]] <= wr_hold;
endmodule : emb_mem_model

// [sim/test_external_memory_bus_port.sv]
// self-checking bench for the external memory bus port
`timescale 1ns/10ps
module test_external_memory_bus_port;
  import emb_pkg::*;
  logic ref_clk, rst, req_valid, req_ready, req_write, rd_valid, power_down, emulation_float_n;
  logic ready, ext_address_bus_oe_n, ext_data_bus_oe_n, data_space_select_n;
  logic program_space_select_n, io_space_select_n, global_space_request_n;
  logic external_cycle_strobe_n, read_write_dir, write_read_dir_n, write_enable_n;
  logic ctrl_oe_n, write_enable_oe_n;
  logic [1:0]  req_space;
  logic [3:0]  slow;
  logic [6:0]  seen_sel;
  logic [15:0] req_addr, req_wdata, rd_data, ext_address_bus, ext_data_bus, ext_data_bus_in;
  logic [15:0] seen_adr, seen_rd;
  logic [3:0]  sel_tab [4] = '{4'h7, 4'hB, 4'hD, 4'h6};
  int          bad_count, compares, cyc, seen_cnt;
  emb_port i_dut (
    .ref_clk, .rst, .req_valid, .req_ready, .req_write, .req_space, .req_addr, .req_wdata,
    .rd_valid, .rd_data, .power_down, .emulation_float_n, .ready, .ext_address_bus,
    .ext_address_bus_oe_n, .ext_data_bus_in, .ext_data_bus, .ext_data_bus_oe_n,
    .data_space_select_n, .program_space_select_n, .io_space_select_n,
    .global_space_request_n, .external_cycle_strobe_n, .read_write_dir, .write_read_dir_n,
    .write_enable_n, .ctrl_oe_n, .write_enable_oe_n);
  emb_mem_model i_mem (
    .ref_clk, .strobe_n(ctrl_oe_n | external_cycle_strobe_n), .rw(read_write_dir),
    .we_n(write_enable_oe_n | write_enable_n), .addr(ext_address_bus),
    .dbus(ext_data_bus_oe_n ? 16'hFFFF : ext_data_bus), .slow, .ready,
    .rdata(ext_data_bus_in));
  // clock, and cycle ceiling against hangs
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // record pins while strobe is low, and returned read data
  always @(negedge ref_clk) begin
    if (external_cycle_strobe_n === 1'b0) begin
      seen_sel <= {data_space_select_n, program_space_select_n, io_space_select_n,
                   global_space_request_n, read_write_dir, write_read_dir_n, ext_data_bus_oe_n};
      seen_adr <= ext_address_bus;
      seen_cnt <= seen_cnt + 1;
    end
    if (rd_valid === 1'b1) seen_rd <= rd_data;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic req(input logic w, input logic [1:0] sp, input logic [15:0] a, d, input bit hold);
    req_valid = 1'b1;
    req_write = w;
    req_space = sp;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1) @(posedge ref_clk) #1;
    @(posedge ref_clk) #1;
    if (!hold) req_valid = 1'b0;
  endtask : req
  task automatic acc(input logic w, input logic [1:0] sp, input logic [15:0] a, d);
    seen_cnt = 0;
    req(w, sp, a, d, 1'b0);
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk) #1;
      if (seen_cnt > 0 && external_cycle_strobe_n === 1'b1) break;
    end
    @(posedge ref_clk) #1;
  endtask : acc
  task automatic t_spaces();
    logic [15:0] a, d;
    for (int s = 0; s < 4; s++) begin
      a = {s[1:0], 12'h000, s[1:0]};
      d = {s[1:0], 12'h5A3, s[1:0]};
      acc(1'b1, s[1:0], a, d);
      chk({9'h0, seen_sel}, {9'h0, sel_tab[s], 3'h2});
      chk(seen_adr, a);
      chk(i_mem.mem[a[7:0]], d);
      acc(1'b0, s[1:0], a, 16'h0000);
      chk({9'h0, seen_sel}, {9'h0, sel_tab[s], 3'h5});
      chk(seen_rd, d);
      chk(16'(seen_cnt), 16'h0001);
    end
  endtask : t_spaces
  task automatic t_wait();
    slow = 4'h3;
    acc(1'b0, EMB_SP_PROG, 16'h0001, 16'h0000);
    chk(16'(seen_cnt), 16'h0004);
    chk(seen_rd, 16'h568D);
    slow = 4'h0;
  endtask : t_wait
  task automatic t_power();
    power_down = 1'b1;
    seen_cnt = 0;
    for (int i = 0; i < EMB_FIFO_DEPTH; i++) req(1'b1, EMB_SP_DATA, 16'h0040 + 16'(i),
      16'h1200 + 16'(i), 1'b1);
    chk({15'h0, req_ready}, 16'h0000);
    req_valid = 1'b0;
    chk({13'h0, ext_address_bus_oe_n, ctrl_oe_n, ext_data_bus_oe_n}, 16'h0003);
    chk(16'(seen_cnt), 16'h0000);
    power_down = 1'b0;
    slow = 4'h1;
    for (int i = 0; i < 400 && seen_cnt < 64; i++) @(posedge ref_clk) #1;
    repeat (3) @(posedge ref_clk) #1;
    chk(i_mem.mem[8'h40], 16'h1200);
    chk(i_mem.mem[8'h5F], 16'h121F);
    slow = 4'h0;
  endtask : t_power
  task automatic t_float();
    emulation_float_n = 1'b0;
    repeat (2) @(posedge ref_clk) #1;
    chk({12'h0, ext_address_bus_oe_n, ext_data_bus_oe_n, ctrl_oe_n, write_enable_oe_n},
        16'h000F);
    emulation_float_n = 1'b1;
    repeat (2) @(posedge ref_clk) #1;
    chk({14'h0, ext_address_bus_oe_n, ctrl_oe_n}, 16'h0000);
  endtask : t_float
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // reset, then the scenarios in turn
  initial begin
    {rst, req_valid, req_write, req_space, req_addr, req_wdata, power_down} = '0;
    emulation_float_n = 1'b1;
    slow = 4'h0;
    rst = 1'b1;
    repeat (12) @(posedge ref_clk);
    #1 chk({13'h0, ext_data_bus_oe_n, ctrl_oe_n, write_enable_oe_n}, 16'h0007);
    rst = 1'b0;
    repeat (2) @(posedge ref_clk) #1;
    t_spaces();
    t_wait();
    t_power();
    t_float();
    report_and_stop();
  end
endmodule : test_external_memory_bus_port
